//--- hdl/dabt_cfg.svh
`ifndef DABT_CFG_SVH
`define DABT_CFG_SVH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define DABT_IDX_PRELOAD0   8'hD2
`define DABT_IDX_PRELOAD1   8'hD3
`define DABT_IDX_CTRL       8'hD4
`define DABT_IDX_FREQ       8'hD5
`define DABT_IDX_FLAG       8'hDA
`define DABT_IDX_COUNT0     8'hE0
`define DABT_IDX_COUNT1     8'hE1
`define DABT_IDX_IRQ_EN     8'hE2
`define DABT_IDX_IRQ_CLR    8'hE3

// ****************************************************************
// Field positions
// ****************************************************************
`define DABT_RUN1_BIT       7
`define DABT_DIV1_LSB       4
`define DABT_RUN0_BIT       3
`define DABT_DIV0_LSB       0
`define DABT_FSEL1_LSB      4
`define DABT_FSEL0_LSB      0
`define DABT_FLAG1_BIT      3
`define DABT_FLAG0_BIT      2

// ****************************************************************
// Reset values
// ****************************************************************
`define DABT_RST_BYTE       8'h00
`define DABT_RST_FLAGS      2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define DABT_CLK_MHZ        125
`define DABT_BASE_MHZ       8
`define DABT_FSEL_MAX       3
`define DABT_PRE_W          14

`endif

//--- hdl/dabt_pkg.sv
package dabt_pkg;

  typedef logic [7:0]  dabt_byte_t;
  typedef logic [13:0] dabt_pre_t;

  typedef enum logic [1:0]
  {
    DABT_F1M,
    DABT_F2M,
    DABT_F4M,
    DABT_F8M
  } dabt_fsel_t;

endpackage : dabt_pkg

//--- hdl/dabt_timer.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
`include "dabt_cfg.svh"


module dabt_timer
  import dabt_pkg::*;
#(
  parameter int CLK_MHZ  = `DABT_CLK_MHZ,
  parameter int BASE_MHZ = `DABT_BASE_MHZ
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [1:0]  irq_ack,
  output logic             irq
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Zero wait states; every transfer completes OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic             addr_ok;
  logic             take;
  logic             wr_pend_q;
  logic [7:0]       wr_idx_q;
  logic [31:0]      hrdata_q;
  logic             wr_now;
  dabt_byte_t       wbyte;
  logic             rd_take;

  // Upper address bits must be zero, else the access is unmapped
  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign take    = hsel && hready && htrans[1];
  assign wr_now  = wr_pend_q;
  assign wbyte   = hwdata[7:0];
  assign rd_take = take && !hwrite;

  // Index kept for the data phase, when the write data arrive
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take && hwrite && addr_ok;
      wr_idx_q  <= haddr[9:2];
    end
  end

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_now && (wr_idx_q == idx);
  endfunction : wr_hit

  // ****************************************************************
  // Software registers
  // ****************************************************************
  dabt_byte_t       preload_q [2];
  dabt_byte_t       ctrl_q;
  dabt_byte_t       freq_q;
  logic [1:0]       irq_en_q;
  logic [1:0]       irq_en_d;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      preload_q[0] <= `DABT_RST_BYTE;
      preload_q[1] <= `DABT_RST_BYTE;
    end
    else
    begin
      // Taken at any time, running or not
      if (wr_hit(`DABT_IDX_PRELOAD0))
        preload_q[0] <= wbyte;
      if (wr_hit(`DABT_IDX_PRELOAD1))
        preload_q[1] <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= `DABT_RST_BYTE;
    else if (wr_hit(`DABT_IDX_CTRL))
      ctrl_q <= wbyte;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      freq_q <= `DABT_RST_BYTE;
    else if (wr_hit(`DABT_IDX_FREQ))
      freq_q <= wbyte;
  end

  // Next enable computed once so irq can follow it in the same clock
  always_comb
  begin
    irq_en_d = irq_en_q;
    if (wr_hit(`DABT_IDX_IRQ_EN))
      irq_en_d = {wbyte[`DABT_FLAG1_BIT], wbyte[`DABT_FLAG0_BIT]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_en_q <= `DABT_RST_FLAGS;
    else
      irq_en_q <= irq_en_d;
  end

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  logic [1:0]       run;
  logic [2:0]       div_code [2];
  dabt_fsel_t       fsel [2];

  assign run[1]      = ctrl_q[`DABT_RUN1_BIT];
  assign run[0]      = ctrl_q[`DABT_RUN0_BIT];
  assign div_code[1] = ctrl_q[`DABT_DIV1_LSB +: 3];
  assign div_code[0] = ctrl_q[`DABT_DIV0_LSB +: 3];
  assign fsel[1]     = dabt_fsel_t'(freq_q[`DABT_FSEL1_LSB +: 2]);
  assign fsel[0]     = dabt_fsel_t'(freq_q[`DABT_FSEL0_LSB +: 2]);

  // ****************************************************************
  // Base tick generator
  // ****************************************************************
  // Fractional accumulator: average rate is exact, jitter one clock.
  // A divider by an integer is impossible since 125 is not a multiple of 8.
  // Limitation: needs BASE_MHZ <= CLK_MHZ <= 256, the accumulator is 8 bits
  logic [7:0]       acc_q;
  logic             base_tick;
  logic [8:0]       acc_sum;

  assign acc_sum   = {1'b0, acc_q} + 9'(BASE_MHZ);
  assign base_tick = (acc_sum >= 9'(CLK_MHZ));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_q <= 8'h00;
    else if (base_tick)
      acc_q <= 8'(acc_sum - 9'(CLK_MHZ));
    else
      acc_q <= acc_sum[7:0];
  end

  // Base ticks per count step: 2^(divider exponent + 3 - freq select)
  function automatic dabt_pre_t step_last(input logic [2:0] code,
                                          input dabt_fsel_t f);
    logic [4:0] e;
    e = 5'h00;
    unique case (code)
      3'h0: e = 5'd0;
      3'h1: e = 5'd1;
      3'h2: e = 5'd2;
      3'h3: e = 5'd3;
      3'h4: e = 5'd4;
      3'h5: e = 5'd6;
      3'h6: e = 5'd8;
      3'h7: e = 5'd10;
    endcase
    e = e + 5'(`DABT_FSEL_MAX) - {3'h0, f};
    step_last = dabt_pre_t'((15'h0001 << e) - 15'h0001);
  endfunction : step_last

  // ****************************************************************
  // Timers
  // ****************************************************************
  dabt_byte_t       count_q [2];
  logic [1:0]       ovf;
  logic [1:0]       run_prev_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_prev_q <= 2'h0;
    else
      run_prev_q <= run;
  end

  for (genvar t = 0; t < 2; t++)
  begin : g_tmr
    dabt_pre_t  pre_q;
    logic       restart;
    logic       pl_wr;
    logic       step;

    assign pl_wr   = wr_hit(t == 0 ? `DABT_IDX_PRELOAD0
                                   : `DABT_IDX_PRELOAD1);
    assign restart = (run[t] && !run_prev_q[t])
                     || (pl_wr && run[t]);
    assign step    = run[t] && base_tick && !restart
                     && (pre_q >= step_last(div_code[t], fsel[t]));
    // Single-cycle pulse per wrap
    assign ovf[t]  = step && (count_q[t] == 8'hFF);

    // Prescaler restarts with the count so the first step is a full period
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        pre_q <= '0;
      else if (restart || !run[t] || step)
        pre_q <= '0;
      else if (base_tick)
        pre_q <= pre_q + dabt_pre_t'(1);
    end

    // A preload write while running wins over a wrap or a step
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        count_q[t] <= `DABT_RST_BYTE;
      else if (restart && pl_wr)
        count_q[t] <= wbyte;
      else if (restart)
        count_q[t] <= preload_q[t];
      else if (ovf[t])
        count_q[t] <= preload_q[t];
      else if (step)
        count_q[t] <= count_q[t] + 8'h01;
      // Disabled: holds its value
    end
  end

  // ****************************************************************
  // Interrupt flags
  // ****************************************************************
  logic [1:0]       flag_q;
  logic [1:0]       flag_d;
  logic [1:0]       clr;
  logic             irq_d;

  // Write 0 to the flag register, write 1 to clear register, or service
  always_comb
  begin
    clr = irq_ack;
    if (wr_hit(`DABT_IDX_FLAG))
      clr = clr | ~{wbyte[`DABT_FLAG1_BIT], wbyte[`DABT_FLAG0_BIT]};
    if (wr_hit(`DABT_IDX_IRQ_CLR))
      clr = clr | {wbyte[`DABT_FLAG1_BIT], wbyte[`DABT_FLAG0_BIT]};
  end

  // Set wins so a wrap in the clearing cycle is kept
  assign flag_d = (flag_q & ~clr) | ovf;
  // Uses the next enable too, so irq has no extra clock of lag
  assign irq_d  = |(flag_d & irq_en_d);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag_q <= `DABT_RST_FLAGS;
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= irq_d;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Snapshot in the address phase; counting is never paused by a read.
  dabt_byte_t       rsel;
  logic [7:0]       flag_byte;

  always_comb
  begin
    flag_byte                  = 8'h00;
    flag_byte[`DABT_FLAG1_BIT] = flag_q[1];
    flag_byte[`DABT_FLAG0_BIT] = flag_q[0];
    rsel = 8'h00;
    if (addr_ok)
    begin
      unique case (haddr[9:2])
        `DABT_IDX_PRELOAD0: rsel = preload_q[0];
        `DABT_IDX_PRELOAD1: rsel = preload_q[1];
        `DABT_IDX_CTRL:     rsel = ctrl_q;
        `DABT_IDX_FREQ:     rsel = freq_q;
        `DABT_IDX_FLAG:     rsel = flag_byte;
        `DABT_IDX_COUNT0:   rsel = count_q[0];
        `DABT_IDX_COUNT1:   rsel = count_q[1];
        `DABT_IDX_IRQ_EN:
        begin
          rsel                  = 8'h00;
          rsel[`DABT_FLAG1_BIT] = irq_en_q[1];
          rsel[`DABT_FLAG0_BIT] = irq_en_q[0];
        end
        default:            rsel = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (rd_take)
      hrdata_q <= {24'h000000, rsel};
  end

  assign hrdata = hrdata_q;

endmodule : dabt_timer

//--- tb/dabt_timer_asserts.sv
`timescale 1ns/1ns

// ****
// Port checks
// ****
module dabt_timer_asserts
  import dabt_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire rd_ph = hsel && hready && htrans[1] && !hwrite;

  // Mask write: address phase, then data phase with both bits low
  sequence s_en_off;
    hsel && hready && htrans[1] && hwrite && haddr == 32'h388
    ##1 hwdata[3:2] == 2'h0;
  endsequence

  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_top: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  a_rdata_hold: assert property (!rd_ph |=> $stable(hrdata))
    else $error("hrdata changed without read");
  a_odd_addr: assert property (rd_ph && haddr[1:0] != 2'h0 |=> hrdata == 0)
    else $error("misaligned read not zero");
  a_high_addr: assert property (rd_ph && haddr[31:10] != 0 |=> hrdata == 0)
    else $error("high address read not zero");
  a_clr_reads: assert property (rd_ph && haddr == 32'h38C |=> hrdata == 0)
    else $error("clear register read not zero");
  // Registered irq falls with the mask register, no lag; the window allows one spare clock
  a_irq_mask: assert property (s_en_off |-> ##[1:2] !irq)
    else $error("irq stays high when masked");
endmodule : dabt_timer_asserts

bind dabt_timer dabt_timer_asserts chk_u (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq);

//--- tb/dabt_timer_tb.sv
`timescale 1ns/1ns

// ****
// Bench
// ****
module dabt_timer_tb;
  import dabt_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  irq_ack = 2'h0;
  wire         hready;
  wire         hresp;
  wire         irq;
  wire  [31:0] hrdata;
  logic [31:0] c;
  logic [31:0] d;
  logic [31:0] ra [8] = '{32'h348, 32'h34C, 32'h350, 32'h354,
                          32'h368, 32'h380, 32'h384, 32'h388};
  int          err_count = 0;
  int          checked   = 0;

  always #4 hclk = ~hclk;

  // Base tick every clock keeps the fast settings at one step per clock
  dabt_timer #(.CLK_MHZ(8), .BASE_MHZ(8)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .irq_ack(irq_ack), .irq(irq));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask : cyc

  task automatic wrdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      err_count++;
      close_out();
    end
  endtask : wrdy

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] wd);
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    wrdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wrdy();
    c = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    bus(a, 1'b1, v);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100)
    begin
      err_count++;
      close_out();
    end
  endtask : wait_irq

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk(c, 32'h0);
    end
    chk(irq, 1'b0);
    $display("test reset done");
    wr(32'h348, 32'hFD);
    wr(32'h354, 32'h33);
    wr(32'h350, 32'h08);
    cyc(20);
    rd(32'h368);
    chk(c, 32'h04);
    wr(32'h350, 32'h00);
    rd(32'h380);
    d = c;
    cyc(10);
    rd(32'h380);
    chk(c, d);
    chk(c[7:0] >= 8'hFD, 1'b1);
    wr(32'h368, 32'hFF);
    rd(32'h368);
    chk(c, 32'h04);
    wr(32'h368, 32'h00);
    rd(32'h368);
    chk(c, 32'h00);
    wr(32'h388, 32'h04);
    wr(32'h350, 32'h08);
    wait_irq();
    chk(irq, 1'b1);
    wr(32'h350, 32'h00);
    wr(32'h388, 32'h00);
    cyc(2);
    chk(irq, 1'b0);
    rd(32'h368);
    chk(c, 32'h04);
    wr(32'h38C, 32'h04);
    rd(32'h368);
    chk(c, 32'h00);
    $display("test timer0 done");
    // Slowest ladder step: at most one step before the read
    wr(32'h34C, 32'h10);
    wr(32'h354, 32'h03);
    wr(32'h350, 32'hF0);
    cyc(20);
    rd(32'h384);
    chk(c[7:1], 7'h08);
    wr(32'h354, 32'h33);
    wr(32'h350, 32'h80);
    wr(32'h34C, 32'h80);
    cyc(1);
    rd(32'h384);
    chk(c[7:2], 6'h20);
    cyc(300);
    wr(32'h350, 32'h00);
    rd(32'h368);
    chk(c, 32'h08);
    irq_ack <= 2'h2;
    cyc(1);
    irq_ack <= 2'h0;
    rd(32'h368);
    chk(c, 32'h00);
    $display("test timer1 done");
    // Divide by four at 8 MHz: about ten steps in forty clocks
    wr(32'h348, 32'h00);
    wr(32'h350, 32'h0A);
    cyc(40);
    rd(32'h380);
    chk(c[7:2], 6'h02);
    // Service right after a wrap must leave the flag clear
    wr(32'h348, 32'hFE);
    wr(32'h388, 32'h04);
    wait_irq();
    irq_ack <= 2'h1;
    cyc(1);
    irq_ack <= 2'h0;
    cyc(1);
    chk(irq, 1'b0);
    wr(32'h350, 32'h00);
    wr(32'h388, 32'h00);
    $display("test divider done");
    rd(32'h34A);
    chk(c, 32'h0);
    rd(32'h1000348);
    chk(c, 32'h0);
    rd(32'h38C);
    chk(c, 32'h0);
    $display("test unmapped done");
    close_out();
  end
endmodule : dabt_timer_tb
